// ---- shared/acq_trig_regs.vh ----
`ifndef ACQ_TRIG_REGS_VH
`define ACQ_TRIG_REGS_VH
// Register byte offsets
`define REG_CTRL        12'h000
`define REG_CMD         12'h004
`define REG_COUNT       12'h008
`define REG_BURST       12'h00c
`define REG_SHUTTER     12'h010
`define REG_TDELAY      12'h014
`define REG_TRATE       12'h018
`define REG_ARATE       12'h01c
`define REG_STATUS      12'h020
`define REG_READOUT     12'h024
// Control field positions
`define CTRL_RUNMODE_LO 0
`define CTRL_RUNMODE_HI 1
`define CTRL_RATE_EN    2
`define CTRL_SHUT_MODE  3
`define CTRL_AUTO_LO    4
`define CTRL_AUTO_HI    5
`define CTRL_TRIG_EN    6
`define CTRL_KIND_LO    7
`define CTRL_KIND_HI    8
`define CTRL_ORIG_LO    9
`define CTRL_ORIG_HI    11
`define CTRL_POL_LO     12
`define CTRL_POL_HI     14
`define CTRL_OVERLAP    15
// Command bits
`define CMD_BEGIN       0
`define CMD_END         1
`define CMD_HOSTTRIG    2
// Encodings
`define RUN_CONT        2'h0
`define RUN_FIXED       2'h1
`define RUN_SINGLE      2'h2
`define AUTO_OFF        2'h0
`define AUTO_ONCE       2'h1
`define AUTO_CONT       2'h2
`define KIND_ACQ        2'h0
`define KIND_FRAME      2'h1
`define KIND_BURST      2'h2
`define ORIG_LINE       3'h0
`define ORIG_USER       3'h1
`define ORIG_COUNTER    3'h2
`define ORIG_LOGIC      3'h3
`define ORIG_SOFT       3'h4
`define POL_LOW         3'h0
`define POL_HIGH        3'h1
`define POL_FALL        3'h2
`define POL_RISE        3'h3
`define POL_ANY         3'h4
// Reset values
`define CTRL_RESET      32'h00000020
`define COUNT_RESET     16'h0001
`define BURST_RESET     16'h0001
`define SHUTTER_RESET   24'h002710
`define TRATE_RESET     16'h001e
// Timing
`define CLK_MHZ         125
`define CYC_PER_US      (`CLK_MHZ)
`define AUTO_ONCE_US    16'h0064
`define RATE_WIN_CYC    32'd125000000
`endif

// ---- hw/acquisition_trigger_control.v ----
// Function
// - Run modes continuous, fixed count, single; continuous after reset, runs until stopped.
// - Fixed count mode captures the capture count, then ends acquisition; burst trigger re-arms instead, frame start ends it after each image.
// - Single mode captures one image, then ends acquisition; under burst trigger it re-arms instead.
// - Begin command starts acquisition, end command stops it.
// - Manual rate flag picks host target rate or automatic rate; clear after reset.
// - Achieved rate is read only and drops when shutter exceeds frame period.
// - Shutter mode timed after reset, or pulse length where trigger sets duration.
// - Timed manual exposure lasts the host written duration in microseconds.
// - Auto shutter once adapts then returns to off; continuous is reset value.
// - Triggering off after reset; active only when trigger enable is set.
// - Trigger kind selects acquisition start, frame start or burst start.
// - Acquisition start trigger begins run: one, count, or continuous until stop.
// - Frame start in single or fixed needs new begin command after each image.
// - Frame start in continuous captures one image per trigger, no restart.
// - Burst trigger captures burst count, capture count, or one per run mode.
// - Trigger origin selects line, user output, counter, logic block or software.
// - Activation is low level, high level, falling, rising or any edge.
// - Overlap off ignores triggers in readout; overlap on starts next image.
// - Programmable microsecond delay between trigger and exposure start.
// - Write only host trigger acts only when origin is software.
`include "acq_trig_regs.vh"
`timescale 1ns/1ps
`default_nettype none
module acquisition_trigger_control #(
  parameter READOUT_CYC = 16'h0400,
  parameter RATE_WIN    = `RATE_WIN_CYC
) (
  input  wire        ref_clk,     // System clock 125 MHz
  input  wire        rstn,        // Synchronous reset, active low
  input  wire [11:0] paddr,       // APB address
  input  wire        psel,        // APB select
  input  wire        penable,     // APB enable
  input  wire        pwrite,      // APB direction
  input  wire [31:0] pwdata,      // APB write data
  output reg  [31:0] prdata,      // APB read data
  output reg         pready,      // APB ready
  output reg         pslverr,     // APB error
  input  wire        lineIn,      // Physical input line
  input  wire        userOut,     // User output signal
  input  wire        counterOut,  // Counter output
  input  wire        logicOut,    // Logic block output
  output reg         exposing,    // Sensor exposure active
  output reg         readingOut,  // Sensor readout active
  output reg         acquiring    // Acquisition running
);
  localparam ST_IDLE  = 3'h0;
  localparam ST_ARMED = 3'h1;
  localparam ST_DELAY = 3'h2;
  localparam ST_EXPO  = 3'h3;
  localparam ST_WAIT  = 3'h4;

  reg  [31:0] ctrl;
  reg  [15:0] captureCount;
  reg  [15:0] burstCount;
  reg  [23:0] shutterDurationUs;
  reg  [15:0] trigDelayUs;
  reg  [15:0] targetRate;
  reg  [15:0] achievedRate;
  reg  [2:0]  state;
  reg  [15:0] framesLeft;
  reg  [15:0] frameSeen;
  reg  [6:0]  usDiv;
  reg  [23:0] usCnt;
  reg  [15:0] roCnt;
  reg  [31:0] periodCnt;
  reg  [31:0] winCnt;
  reg  [15:0] winFrames;
  reg  [15:0] onceCnt;
  reg         trigPrev;
  reg         hostTrig;
  reg         needBegin;
  reg         trigHeld;
  reg         srcSel;
  reg  [1:0]  runMode;
  reg  [1:0]  kind;
  reg  [15:0] perTrig;
  reg         trigEvent;
  reg         trigLevel;
  wire        usTick = (usDiv == `CYC_PER_US - 1);
  wire        apbWr  = psel & penable & pwrite & pready;
  wire        apbRd  = psel & ~pready & ~pwrite;
  wire        cmdWr  = apbWr & (paddr == `REG_CMD);
  wire        beginCmd = cmdWr & pwdata[`CMD_BEGIN];
  wire        endCmd   = cmdWr & pwdata[`CMD_END];
  wire        pulseMode = ctrl[`CTRL_SHUT_MODE];
  wire [2:0]  pol = ctrl[`CTRL_POL_HI:`CTRL_POL_LO];
  wire [31:0] framePeriod = (targetRate == 16'h0000) ? 32'hffffffff :
                            (RATE_WIN / {16'h0000, targetRate});

  // Trigger source mux and activation decoding
  always @*
  begin
    runMode = ctrl[`CTRL_RUNMODE_HI:`CTRL_RUNMODE_LO];
    kind    = ctrl[`CTRL_KIND_HI:`CTRL_KIND_LO];
    case (ctrl[`CTRL_ORIG_HI:`CTRL_ORIG_LO])
      `ORIG_LINE:    srcSel = lineIn;
      `ORIG_USER:    srcSel = userOut;
      `ORIG_COUNTER: srcSel = counterOut;
      `ORIG_LOGIC:   srcSel = logicOut;
      `ORIG_SOFT:    srcSel = hostTrig;
      default:       srcSel = 1'b0;
    endcase
    case (pol)
      `POL_LOW:  trigEvent = ~srcSel & ~trigHeld;
      `POL_HIGH: trigEvent = srcSel & ~trigHeld;
      `POL_FALL: trigEvent = trigPrev & ~srcSel;
      `POL_RISE: trigEvent = ~trigPrev & srcSel;
      `POL_ANY:  trigEvent = trigPrev ^ srcSel;
      default:   trigEvent = 1'b0;
    endcase
    trigLevel = (pol == `POL_LOW || pol == `POL_FALL) ? ~srcSel : srcSel;
    if (ctrl[`CTRL_ORIG_HI:`CTRL_ORIG_LO] == `ORIG_SOFT)
      trigLevel = hostTrig;
    // Images per accepted trigger
    case (kind)
      `KIND_BURST:
        perTrig = (runMode == `RUN_SINGLE) ? 16'h0001 :
                  (runMode == `RUN_FIXED) ? captureCount : burstCount;
      `KIND_FRAME:
        perTrig = (runMode == `RUN_FIXED) ? captureCount : 16'h0001;
      default:
        perTrig = (runMode == `RUN_SINGLE) ? 16'h0001 : captureCount;
    endcase
  end

  // APB register writes and reads
  always @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      ctrl              <= `CTRL_RESET;
      captureCount      <= `COUNT_RESET;
      burstCount        <= `BURST_RESET;
      shutterDurationUs <= `SHUTTER_RESET;
      trigDelayUs       <= 16'h0000;
      targetRate        <= `TRATE_RESET;
      hostTrig          <= 1'b0;
      pready            <= 1'b0;
      pslverr           <= 1'b0;
      prdata            <= 32'h00000000;
      onceCnt           <= 16'h0000;
    end
    else
    begin
      pready   <= psel & ~pready;
      pslverr  <= 1'b0;
      hostTrig <= cmdWr & pwdata[`CMD_HOSTTRIG];
      // One-shot auto exposure reverts to off after adapting
      if (ctrl[`CTRL_AUTO_HI:`CTRL_AUTO_LO] == `AUTO_ONCE && usTick)
        onceCnt <= onceCnt + 16'h0001;
      if (onceCnt == `AUTO_ONCE_US)
      begin
        ctrl[`CTRL_AUTO_HI:`CTRL_AUTO_LO] <= `AUTO_OFF;
        onceCnt <= 16'h0000;
      end
      if (apbWr)
      begin
        case (paddr)
          `REG_CTRL:    ctrl <= {16'h0000, pwdata[15:0]};
          `REG_COUNT:   captureCount <= pwdata[15:0];
          `REG_BURST:   burstCount <= pwdata[15:0];
          `REG_SHUTTER: shutterDurationUs <= pwdata[23:0];
          `REG_TDELAY:  trigDelayUs <= pwdata[15:0];
          `REG_TRATE:   targetRate <= pwdata[15:0];
          `REG_CMD:     ;
          default:      ;
        endcase
      end
      // Error is decided in setup so it stands with ready
      if (psel & ~pready)
        pslverr <= (paddr > `REG_READOUT) | (paddr[1:0] != 2'b00) |
                   (pwrite & ((paddr == `REG_ARATE) |
                              (paddr == `REG_STATUS) |
                              (paddr == `REG_READOUT)));
      // Read data loaded in setup, valid when ready is seen
      if (apbRd)
      begin
        case (paddr)
          `REG_CTRL:    prdata <= ctrl;
          `REG_COUNT:   prdata <= {16'h0000, captureCount};
          `REG_BURST:   prdata <= {16'h0000, burstCount};
          `REG_SHUTTER: prdata <= {8'h00, shutterDurationUs};
          `REG_TDELAY:  prdata <= {16'h0000, trigDelayUs};
          `REG_TRATE:   prdata <= {16'h0000, targetRate};
          `REG_ARATE:   prdata <= {16'h0000, achievedRate};
          `REG_STATUS:  prdata <= {26'h0, needBegin, readingOut,
                                   exposing, state};
          `REG_READOUT: prdata <= {16'h0000, framesLeft};
          `REG_CMD:     prdata <= 32'h00000000;  // write only
          default:      prdata <= 32'h00000000;
        endcase
      end
    end
  end

  // Acquisition sequencer
  always @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      state      <= ST_IDLE;
      framesLeft <= 16'h0000;
      usDiv      <= 7'h00;
      usCnt      <= 24'h000000;
      roCnt      <= 16'h0000;
      periodCnt  <= 32'h00000000;
      trigPrev   <= 1'b0;
      trigHeld   <= 1'b0;
      needBegin  <= 1'b0;
      exposing   <= 1'b0;
      readingOut <= 1'b0;
      acquiring  <= 1'b0;
      frameSeen  <= 16'h0000;
    end
    else
    begin
      trigPrev  <= srcSel;
      trigHeld  <= trigLevel & (trigHeld | trigEvent);
      // Free-running prescaler, restarted whenever a timed phase begins
      usDiv     <= usTick ? 7'h00 : usDiv + 7'h01;
      frameSeen <= 16'h0000;
      if (periodCnt != 32'hffffffff)
        periodCnt <= periodCnt + 32'h00000001;
      // Readout runs independently so overlap can start the next image
      if (roCnt != 16'h0000)
        roCnt <= roCnt - 16'h0001;
      readingOut <= (roCnt > 16'h0001);
      case (state)
        ST_IDLE:
        begin
          if (beginCmd)
          begin
            acquiring <= 1'b1;
            needBegin <= 1'b0;
            framesLeft <= (runMode == `RUN_SINGLE) ? 16'h0001 :
                          captureCount;
            state <= ST_ARMED;
          end
        end
        ST_ARMED:
        begin
          if (!ctrl[`CTRL_TRIG_EN])
          begin
            if (!ctrl[`CTRL_RATE_EN] || periodCnt >= framePeriod)
            begin
              usCnt <= 24'h000000;
              usDiv <= 7'h01;  // Exact microsecond count from entry
              state <= ST_EXPO;
              exposing <= 1'b1;
              periodCnt <= 32'h00000000;
            end
          end
          else if (trigEvent && !needBegin &&
                   (ctrl[`CTRL_OVERLAP] || roCnt == 16'h0000))
          begin
            framesLeft <= perTrig;
            usCnt <= 24'h000000;
            usDiv <= 7'h01;
            state <= ST_DELAY;
          end
        end
        ST_DELAY:
        begin
          if (usTick)
            usCnt <= usCnt + 24'h000001;
          if (usCnt >= {8'h00, trigDelayUs})
          begin
            usCnt <= 24'h000000;
            usDiv <= 7'h01;
            exposing <= 1'b1;
            periodCnt <= 32'h00000000;
            state <= ST_EXPO;
          end
        end
        ST_EXPO:
        begin
          if (usTick)
            usCnt <= usCnt + 24'h000001;
          if ((pulseMode && ctrl[`CTRL_TRIG_EN]) ? !trigLevel :
              (usCnt >= shutterDurationUs))
          begin
            exposing <= 1'b0;
            roCnt <= READOUT_CYC;
            frameSeen <= 16'h0001;
            framesLeft <= framesLeft - 16'h0001;
            state <= ST_WAIT;
          end
        end
        ST_WAIT:
        begin
          if (ctrl[`CTRL_OVERLAP] || roCnt == 16'h0000)
          begin
            if (framesLeft != 16'h0000 &&
                (!ctrl[`CTRL_TRIG_EN] || kind == `KIND_BURST ||
                 kind == `KIND_ACQ && runMode != `RUN_CONT))
            begin
              if (ctrl[`CTRL_TRIG_EN])
              begin
                usCnt <= 24'h000000;
                usDiv <= 7'h01;
                exposing <= 1'b1;
                periodCnt <= 32'h00000000;
                state <= ST_EXPO;
              end
              else
                state <= ST_ARMED;
            end
            else if (kind == `KIND_ACQ && ctrl[`CTRL_TRIG_EN] &&
                     runMode == `RUN_CONT)
            begin
              framesLeft <= 16'h0001;
              exposing <= 1'b1;
              usCnt <= 24'h000000;
              usDiv <= 7'h01;
              state <= ST_EXPO;
            end
            else if (runMode == `RUN_CONT && !ctrl[`CTRL_TRIG_EN])
            begin
              framesLeft <= 16'h0001;
              state <= ST_ARMED;
            end
            else if (ctrl[`CTRL_TRIG_EN] && (runMode == `RUN_CONT ||
                     kind == `KIND_BURST))
              state <= ST_ARMED;
            else if (ctrl[`CTRL_TRIG_EN] && kind == `KIND_FRAME)
            begin
              needBegin <= 1'b1;
              state <= ST_IDLE;
              acquiring <= 1'b0;
            end
            else
            begin
              state <= ST_IDLE;
              acquiring <= 1'b0;
            end
          end
        end
        default: state <= ST_IDLE;
      endcase
      if (endCmd)
      begin
        state <= ST_IDLE;
        exposing <= 1'b0;
        acquiring <= 1'b0;
      end
    end
  end

  // Achieved rate: frames completed per one-second window
  always @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      winCnt       <= 32'h00000000;
      winFrames    <= 16'h0000;
      achievedRate <= 16'h0000;
    end
    else if (winCnt >= RATE_WIN - 1)
    begin
      winCnt       <= 32'h00000000;
      achievedRate <= winFrames + frameSeen;
      winFrames    <= 16'h0000;
    end
    else
    begin
      winCnt    <= winCnt + 32'h00000001;
      winFrames <= winFrames + frameSeen;
    end
  end
endmodule
`default_nettype wire

// ---- tb/acq_trig_sva.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "acq_trig_regs.vh"
module acq_trig_sva (
  input wire logic        ref_clk,    // Clock
  input wire logic        rstn,       // Sync reset, active low
  input wire logic [11:0] paddr,      // APB address
  input wire logic        psel,       // APB select
  input wire logic        penable,    // APB enable
  input wire logic        pwrite,     // APB direction
  input wire logic [31:0] pwdata,     // APB write data
  input wire logic        pready,     // APB ready
  input wire logic        pslverr,    // APB error
  input wire logic        exposing,   // Exposure active
  input wire logic        readingOut, // Readout active
  input wire logic        acquiring   // Run active
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  logic        wrDone;
  logic        begWr;
  logic        endWr;
  logic [31:0] ctrl;
  logic [15:0] cnt;
  logic [23:0] shut;
  logic [31:0] expLen;
  logic [15:0] frames;
  logic        expPrev;
  logic        endSeen;

  // Completed host writes
  assign wrDone = psel && penable && pready && pwrite;
  assign begWr  = wrDone && paddr == `REG_CMD && pwdata[`CMD_BEGIN];
  assign endWr  = wrDone && paddr == `REG_CMD && pwdata[`CMD_END];

  // Shadow settings, count frames of a run and cycles of an exposure
  always @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      ctrl    <= `CTRL_RESET;
      cnt     <= `COUNT_RESET;
      shut    <= `SHUTTER_RESET;
      frames  <= 16'h0000;
      endSeen <= 1'b0;
    end
    else
    begin
      if (wrDone && paddr == `REG_CTRL)
        ctrl <= pwdata;
      if (wrDone && paddr == `REG_COUNT)
        cnt <= pwdata[15:0];
      if (wrDone && paddr == `REG_SHUTTER)
        shut <= pwdata[23:0];
      if (begWr)
        frames <= 16'h0000;
      else if (exposing && !expPrev)
        frames <= frames + 16'h0001;
      if (begWr || endWr)
        endSeen <= endWr;
    end
    expPrev <= exposing;
    expLen  <= exposing ? expLen + 32'h1 : 32'h0;
  end

  sequence s_run;
    ##[1:3] acquiring;
  endsequence

  sequence s_stop;
    ##[1:3] !acquiring;
  endsequence

  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held longer than one cycle");
  chk_ready_cause: assert property (pready |-> psel && penable && $past(psel))
    else $error("ready without an access phase");
  chk_bad_addr: assert property (psel && penable && pready &&
      (paddr[1:0] != 2'h0 || paddr > `REG_READOUT) |-> pslverr)
    else $error("unmapped access not refused");
  chk_reset_quiet: assert property ($rose(rstn) |->
      !acquiring && !exposing && !readingOut)
    else $error("activity right after reset");
  chk_begin_runs: assert property (begWr && !ctrl[`CTRL_TRIG_EN] |-> s_run)
    else $error("begin command did not start a run");
  chk_end_stops: assert property (endWr |-> s_stop)
    else $error("end command did not stop the run");
  chk_expose_inrun: assert property ($rose(exposing) |-> acquiring)
    else $error("exposure outside a run");
  chk_timed_len: assert property ($fell(exposing) && !endSeen &&
      !ctrl[`CTRL_SHUT_MODE] && ctrl[5:4] == `AUTO_OFF |->
      expLen == {8'h00, shut} * 32'd125)
    else $error("timed exposure length wrong");
  chk_frame_total: assert property ($fell(acquiring) && !endSeen &&
      !ctrl[`CTRL_TRIG_EN] && ctrl[1:0] != `RUN_CONT |->
      frames == (ctrl[1:0] == `RUN_SINGLE ? 16'h0001 : cnt))
    else $error("wrong number of frames in run");
endmodule

bind acquisition_trigger_control acq_trig_sva chk_u (.ref_clk(ref_clk),
  .rstn(rstn), .paddr(paddr), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
  .exposing(exposing), .readingOut(readingOut), .acquiring(acquiring));
`default_nettype wire

// ---- tb/trig_source_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module trig_source_model (
  input  wire logic ref_clk,    // Clock
  output wire logic lineIn,     // Physical input line
  output wire logic userOut,    // User output
  output wire logic counterOut, // Counter output
  output wire logic logicOut    // Logic block output
);
  logic [3:0] lvl = 4'h0;

  // Sources idle low; a pulse makes one rising and one falling edge
  assign lineIn     = lvl[0];
  assign userOut    = lvl[1];
  assign counterOut = lvl[2];
  assign logicOut   = lvl[3];

  // Raise one source for some cycles, changed just after an edge
  task automatic fire(input logic [1:0] src, input int width);
    lvl[src] <= 1'b1;
    repeat (width) @(posedge ref_clk);
    lvl[src] <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ---- tb/tb_acquisition_trigger_control.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "acq_trig_regs.vh"
`define CHECK(g, e) begin cmp_count++; if ((g) !== (e)) begin \
  n_mismatch++; $display("MISMATCH %0t got %h exp %h", $time, g, e); end end
module tb_acquisition_trigger_control;
  logic        ref_clk = 1'b0;
  logic        rstn = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready, pslverr, exposing, readingOut, acquiring;
  logic        lineIn, userOut, counterOut, logicOut;
  logic        expPrev = 1'b0;
  int          n_mismatch = 0, cmp_count = 0, cyc = 0, nFrames = 0, expCyc = 0;

  acquisition_trigger_control #(.READOUT_CYC(16'h0010), .RATE_WIN(32'd1000))
  dut_u (.ref_clk(ref_clk), .rstn(rstn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .lineIn(lineIn), .userOut(userOut),
    .counterOut(counterOut), .logicOut(logicOut), .exposing(exposing),
    .readingOut(readingOut), .acquiring(acquiring));
  trig_source_model partner_u (.ref_clk(ref_clk), .lineIn(lineIn),
    .userOut(userOut), .counterOut(counterOut), .logicOut(logicOut));

  initial
    forever #4 ref_clk = ~ref_clk;

  // Count exposure starts and cycles of the latest one; cut a hang
  always @(posedge ref_clk)
  begin
    expPrev <= exposing;
    if (exposing && !expPrev)
      nFrames <= nFrames + 1;
    if (exposing)
      expCyc <= expPrev ? expCyc + 1 : 1;
    cyc <= cyc + 1;
    if (cyc == 60000)
    begin
      n_mismatch++;
      close_out();
    end
  end

  // One APB transfer, held until ready is seen at an edge
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    int n;
    n = 0;
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1 && n < 50)
    begin
      @(posedge ref_clk);
      n++;
    end
    if (n >= 50)
      n_mismatch++;
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] x,
                    input logic xe);
    logic [31:0] q;
    logic        e;
    apb(1'b0, a, 32'h0, q, e);
    `CHECK(e, xe)
    if (!xe)
      `CHECK(q, x)
  endtask

  // Wait for exposure and readout to end, then let the rate timer idle
  task automatic settle();
    int n;
    n = 0;
    while ((exposing || readingOut) && n < 5000)
    begin
      @(posedge ref_clk);
      n++;
    end
    repeat (200) @(posedge ref_clk);
  endtask

  task automatic wait_acq(input logic v);
    int n;
    n = 0;
    while (acquiring !== v && n < 20000)
    begin
      @(posedge ref_clk);
      n++;
    end
  endtask

  task automatic t_regs();
    rd(`REG_CTRL, `CTRL_RESET, 1'b0);
    rd(`REG_COUNT, 32'h1, 1'b0);
    rd(`REG_BURST, 32'h1, 1'b0);
    rd(`REG_SHUTTER, 32'h2710, 1'b0);
    rd(`REG_CMD, 32'h0, 1'b0);
    rd(12'h030, 32'h0, 1'b1);
    rd(12'h002, 32'h0, 1'b1);
    `CHECK(acquiring, 1'b0)
  endtask

  task automatic t_runs();
    logic [1:0] m[2];
    int         k[2];
    int         f0;
    m = '{`RUN_SINGLE, `RUN_FIXED};
    k = '{1, 3};
    wr(`REG_SHUTTER, 32'h2);
    wr(`REG_COUNT, 32'h3);
    for (int i = 0; i < 2; i++)
    begin
      wr(`REG_CTRL, {30'h0, m[i]});
      f0 = nFrames;
      wr(`REG_CMD, 32'h1);
      wait_acq(1'b1);
      wait_acq(1'b0);
      `CHECK(nFrames - f0, k[i])
      settle();
      `CHECK(expCyc, 250)
    end
  endtask

  task automatic t_cont();
    int f0;
    int n;
    n = 0;
    wr(`REG_CTRL, 32'h0);
    f0 = nFrames;
    wr(`REG_CMD, 32'h1);
    while (nFrames - f0 < 3 && n < 20000)
    begin
      @(posedge ref_clk);
      n++;
    end
    `CHECK(acquiring, 1'b1)
    wr(`REG_CMD, 32'h2);
    repeat (3) @(posedge ref_clk);
    `CHECK(acquiring, 1'b0)
    settle();
  endtask

  task automatic t_trig();
    int f0;
    int d;
    wr(`REG_TDELAY, 32'h1);
    wr(`REG_CTRL, 32'h30c0);
    f0 = nFrames;
    wr(`REG_CMD, 32'h1);
    repeat (400) @(posedge ref_clk);
    `CHECK(nFrames - f0, 0)
    for (int s = 0; s < 4; s++)
    begin
      wr(`REG_CTRL, 32'h30c0 | (s << 9));
      f0 = nFrames;
      partner_u.fire(s[1:0], 4);
      d = 4;
      while (!exposing && d < 400)
      begin
        @(posedge ref_clk);
        d++;
      end
      `CHECK(d >= 125 && d <= 140, 1'b1)
      settle();
      `CHECK(nFrames - f0, 1)
    end
  endtask

  task automatic t_soft();
    int f0;
    wr(`REG_CTRL, 32'h38c0);
    f0 = nFrames;
    wr(`REG_CMD, 32'h4);
    settle();
    `CHECK(nFrames - f0, 1)
    wr(`REG_CTRL, 32'h30c0);
    f0 = nFrames;
    wr(`REG_CMD, 32'h4);
    settle();
    `CHECK(nFrames - f0, 0)
    wr(`REG_CMD, 32'h2);
  endtask

  // Manual rate above what the shutter allows, then one-shot auto revert
  task automatic t_rate();
    logic [31:0] q;
    logic        e;
    wr(`REG_TRATE, 32'ha);
    wr(`REG_CTRL, 32'h4);
    wr(`REG_CMD, 32'h1);
    repeat (2100) @(posedge ref_clk);
    apb(1'b0, `REG_ARATE, 32'h0, q, e);
    `CHECK(q != 32'h0 && q < 32'ha, 1'b1)
    wr(`REG_CMD, 32'h2);
    settle();
    wr(`REG_CTRL, 32'h10);
    repeat (12700) @(posedge ref_clk);
    rd(`REG_CTRL, 32'h0, 1'b0);
  endtask

  task automatic close_out();
    if (n_mismatch == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Reset, then the scenarios in order
  initial
  begin
    repeat (20) @(posedge ref_clk);
    rstn <= 1'b1;
    @(posedge ref_clk);
    t_regs();
    t_runs();
    t_cont();
    t_trig();
    t_soft();
    t_rate();
    close_out();
  end
endmodule
`default_nettype wire
